// >>> hw/led_brightness_fader.sv
// ============================================================================
// brightness level of one group, stepping one level per frame when smoothed
module led_brightness_fader
  import led_scan_pkg::*;
#(
  parameter int LVL_W = 3
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // control
  input  wire logic [LVL_W-1:0] target,
  input  wire logic             smoothOff,
  input  wire logic             step,
  // level in use
  output logic      [LVL_W-1:0] level
);

  if (LVL_W != 3) begin : g_chk
    $error("led_brightness_fader supports only 3-bit levels");
  end

  logic [LVL_W-1:0] level_r;

  // jump or walk toward the written level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_r <= LEVEL_RST;
    end else if (smoothOff) begin
      level_r <= target;
    end else if (step && level_r < target) begin
      level_r <= level_r + 1'b1;
    end else if (step && level_r > target) begin
      level_r <= level_r - 1'b1;
    end
  end

  assign level = level_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_FADE_JUMP: assert property (
    smoothOff |=> level == $past(target))
    else $error("unsmoothed level did not follow target");

  AST_FADE_STEP: assert property (
    (!smoothOff && step && level < target) |=> level == $past(level) + 1'b1)
    else $error("smoothed level did not step up by one");

  AST_FADE_HOLD: assert property (
    (!smoothOff && !step) |=> $stable(level))
    else $error("smoothed level moved between frames");

endmodule // led_brightness_fader

// >>> hw/led_matrix_scan_control.sv
// ============================================================================
// LED matrix scan controller with APB register access
//
// Design decision made here: the APB slave port.
module led_matrix_scan_control
  import led_scan_pkg::*;
(
  // clock (fast oscillator) and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // led pattern, six segment bits per common
  input  wire logic [NUM_COM*MAX_SEG-1:0] ledPattern,
  // matrix pins
  output led_pins_s                       ledPins
);

  typedef enum logic [1:0] {SCAN_IDLE, SCAN_RUN, SCAN_HOLD} scan_state_e;

  // ==========================================================================
  // declarations
  logic [7:0]      scanCtrl_r;
  logic [7:0]      brightExtra_r;
  logic [31:0]     prdata_r;
  logic            pready_r;
  logic            pslverr_r;
  scan_cfg_s       cfg;
  scan_state_e     state_r;
  scan_state_e     state_nxt;
  logic            scanTick;
  logic [2:0]      subCnt_r;
  logic [3:0]      slot_r;
  logic [3:0]      lastSlot;
  logic            frameEnd;
  logic [2:0]      segUsed;
  logic [2:0]      groupTarget [3];
  logic [2:0]      groupLevel  [3];
  logic [2:0]      segLevel    [MAX_SEG];
  led_pins_s       pins_r;
  led_pins_s       pins_nxt;
  logic            access;
  logic [31:0]     readData;
  logic            addrHit;

  // ==========================================================================
  // apb slave
  assign access = psel && penable;

  // decode of mapped word addresses
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a == SCAN_CTRL_ADDR) || (a == BRIGHT_EXTRA_ADDR) ||
           (a == SCAN_STATUS_ADDR);
  endfunction

  assign addrHit = isMapped(paddr);

  // read multiplexer, upper bits read as zero
  always_comb begin
    readData = 32'h0;
    if (paddr == SCAN_CTRL_ADDR) begin
      readData = {24'h0, scanCtrl_r};
    end else if (paddr == BRIGHT_EXTRA_ADDR) begin
      readData = {24'h0, brightExtra_r};
    end else if (paddr == SCAN_STATUS_ADDR) begin
      readData = {24'h0, slot_r, 1'b0, subCnt_r == 3'h0,
                  state_r == SCAN_HOLD, state_r == SCAN_RUN};
    end
  end

  // one wait state: answer on the second access cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r <= access && !pready_r;
      if (access && !pready_r) begin
        pslverr_r <= !addrHit;
        prdata_r  <= pwrite ? 32'h0 : readData;
      end else begin
        pslverr_r <= 1'b0;
        prdata_r  <= 32'h0;
      end
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // control registers, written on the completing edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scanCtrl_r    <= SCAN_CTRL_RST;
      brightExtra_r <= EXTRA_RST;
    end else if (access && pready_r && pwrite) begin
      if (paddr == SCAN_CTRL_ADDR) begin
        scanCtrl_r <= pwdata[7:0];
      end
      if (paddr == BRIGHT_EXTRA_ADDR) begin
        brightExtra_r <= pwdata[7:0] & EXTRA_MASK;
      end
    end
  end

  assign cfg = decodeCfg(scanCtrl_r, brightExtra_r);

  // ==========================================================================
  // scan state
  always_comb begin
    if (cfg.duty == DUTY_OFF) begin
      state_nxt = SCAN_IDLE;
    end else if (cfg.freeze) begin
      state_nxt = SCAN_HOLD;
    end else begin
      state_nxt = SCAN_RUN;
    end
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= SCAN_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // scan clock prescaler, counting only while running
  led_scan_divider u_divider (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (state_r == SCAN_RUN),
    .divSel  (cfg.divSel),
    .tick    (scanTick)
  );

  assign lastSlot = slotCount(cfg.duty) - 4'h1;
  assign frameEnd = scanTick && (subCnt_r == SUB_LAST) && (slot_r >= lastSlot);
  assign segUsed  = segCount(cfg.duty);

  // sub-slot and slot counters; hold freezes, idle restarts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      subCnt_r <= 3'h0;
      slot_r   <= 4'h0;
    end else begin
      unique case (state_r)
        SCAN_IDLE: begin
          subCnt_r <= 3'h0;
          slot_r   <= 4'h0;
        end
        SCAN_HOLD: begin
          subCnt_r <= subCnt_r;
          slot_r   <= slot_r;
        end
        SCAN_RUN: begin
          if (scanTick) begin
            subCnt_r <= subCnt_r + 3'h1;
            if (subCnt_r == SUB_LAST) begin
              slot_r <= (slot_r >= lastSlot) ? 4'h0 : slot_r + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // brightness
  assign groupTarget[0] = cfg.mainBri;
  assign groupTarget[1] = cfg.seg4Bri;
  assign groupTarget[2] = cfg.seg5Bri;

  // one fader per brightness group, stepping once per frame
  for (genvar g = 0; g < 3; g++) begin : g_fade
    led_brightness_fader #(
      .LVL_W (3)
    ) u_fader (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .target    (groupTarget[g]),
      .smoothOff (cfg.fadeDis),
      .step      (frameEnd),
      .level     (groupLevel[g])
    );
  end

  // level that applies to each segment line
  always_comb begin
    for (int i = 0; i < MAX_SEG; i++) begin
      if (i < NUM_COM) begin
        segLevel[i] = groupLevel[0];
      end else if (i == NUM_COM) begin
        segLevel[i] = groupLevel[1];
      end else begin
        segLevel[i] = groupLevel[2];
      end
    end
  end

  // ==========================================================================
  // pin drive
  always_comb begin
    pins_nxt = '0; // idle and hold: every pin released
    if (state_r == SCAN_RUN) begin
      pins_nxt.comOe = '1;
      for (int i = 0; i < MAX_SEG; i++) begin
        pins_nxt.segOe[i] = 3'(i) < segUsed;
      end
      if (slot_r < 4'(NUM_COM)) begin
        pins_nxt.common_drive_line[slot_r[1:0]] = 1'b1;
        for (int i = 0; i < MAX_SEG; i++) begin
          pins_nxt.segment_drive_line[i] = pins_nxt.segOe[i] &&
                            ledPattern[int'(slot_r[1:0]) * MAX_SEG + i] &&
                            (subCnt_r <= segLevel[i]);
        end
      end
    end
  end

  // registered pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_r <= '0;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  assign ledPins = pins_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_OFF_IDLE: assert property (
    (cfg.duty == DUTY_OFF) |=> state_r == SCAN_IDLE ##1 ledPins.comOe == 4'h0)
    else $error("scanning active with duty field off");

  AST_DUTY8_SEGS: assert property (
    (state_r == SCAN_RUN && cfg.duty == DUTY_8) |=> ledPins.segOe == 6'h0f)
    else $error("wrong segment lines driven at 1/8 duty");

  AST_DUTY9_SEGS: assert property (
    (state_r == SCAN_RUN && cfg.duty == DUTY_9) |=> ledPins.segOe == 6'h1f)
    else $error("wrong segment lines driven at 1/9 duty");

  AST_DUTY10_SEGS: assert property (
    (state_r == SCAN_RUN && cfg.duty == DUTY_10) |=> ledPins.segOe == 6'h3f)
    else $error("wrong segment lines driven at 1/10 duty");

  AST_FREEZE_HIZ: assert property (
    (cfg.freeze && $past(cfg.freeze)) |=> (ledPins.comOe == 4'h0 && ledPins.segOe == 6'h0))
    else $error("pins driven while scanning is frozen");

  AST_FREEZE_STOP: assert property (
    (state_r == SCAN_HOLD) |=> $stable(slot_r) && $stable(subCnt_r))
    else $error("scan advanced while frozen");

  AST_RUN_DRIVE: assert property (
    (cfg.duty != DUTY_OFF && !cfg.freeze) ##1 (state_r == SCAN_RUN) |=> ledPins.comOe == 4'hf)
    else $error("commons not driven while running");

  AST_ONE_COMMON: assert property (
    (state_r == SCAN_RUN) |=> $onehot0(ledPins.common_drive_line))
    else $error("more than one common active");

  AST_SLOT_WRAP: assert property (
    (state_r == SCAN_RUN && frameEnd) |=> slot_r == 4'h0)
    else $error("slot did not wrap at frame end");

  AST_COMMON_SLOT: assert property (
    (state_r == SCAN_RUN && slot_r < 4'(NUM_COM)) |=> ledPins.common_drive_line == (4'h1 << $past(slot_r[1:0])))
    else $error("wrong common active for the slot");

  AST_BLANK_SLOT: assert property (
    (state_r == SCAN_RUN && slot_r >= 4'(NUM_COM)) |=> ledPins.common_drive_line == 4'h0)
    else $error("common active in a blank slot");

  AST_SLOT_STEP: assert property (
    (state_r == SCAN_RUN && scanTick && subCnt_r == SUB_LAST && !frameEnd) |=>
      slot_r == $past(slot_r) + 4'h1)
    else $error("slot did not advance after eight sub-slots");

  AST_MAIN_PWM: assert property (
    (state_r == SCAN_RUN && subCnt_r > groupLevel[0]) |=> ledPins.segment_drive_line[3:0] == 4'h0)
    else $error("main segments lit beyond brightness on-time");

  AST_SEG4_PWM: assert property (
    (state_r == SCAN_RUN && subCnt_r > groupLevel[1]) |=> !ledPins.segment_drive_line[4])
    else $error("segment 4 lit beyond brightness on-time");

  AST_SEG5_PWM: assert property (
    (state_r == SCAN_RUN && subCnt_r > groupLevel[2]) |=> !ledPins.segment_drive_line[5])
    else $error("segment 5 lit beyond brightness on-time");

endmodule // led_matrix_scan_control

// >>> hw/led_scan_divider.sv
// ============================================================================
// scan clock prescaler: one tick every 64/32/16/8 oscillator cycles
module led_scan_divider
  import led_scan_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // control
  input  wire logic       run,
  input  wire logic [1:0] divSel,
  // scan tick
  output logic            tick
);

  logic [5:0] cnt_r;

  // free count while running, restart when stopped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 6'h0;
    end else if (!run || cnt_r >= divLimit(divSel)) begin
      cnt_r <= 6'h0;
    end else begin
      cnt_r <= cnt_r + 6'h1;
    end
  end

  assign tick = run && (cnt_r >= divLimit(divSel));

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !run || divSel != 2'h3);

  AST_DIV_BY_8: assert property (
    tick |=> (!tick)[*7] ##1 tick)
    else $error("scan tick spacing wrong for divide by 8");

endmodule // led_scan_divider

// >>> pkg/led_scan_pkg.sv
// Summary of operation
// - scan enable/duty field 00 (reset) keeps LED scanning disabled.
// - field 01 scans four commons against four segments at 1/8 duty.
// - field 10 scans four commons against five segments at 1/9 duty.
// - field 11 scans four commons against six segments at 1/10 duty.
// - scan clock is oscillator divided by 64/32/16/8 for codes 00..11; reset 64.
// - freeze bit 1 stops scanning, all common and segment pins high-impedance.
// - freeze bit 0 (reset) runs scanning per enable, duty and divider.
// - 3-bit main brightness for commons 0-3, segments 0-3; 000 dark, reset 100; the code still lights 000 for one sub-slot in eight.
// - 3-bit brightness for segment line 5 LEDs; 000 dark, 111 bright, reset 100; the code still lights 000 for one sub-slot in eight.
// - 3-bit brightness for segment line 4 LEDs; 000 dark, 111 bright, reset 100; the code still lights 000 for one sub-slot in eight.
// - fade-disable bit 0 (reset) smooths brightness changes; 1 jumps directly.
package led_scan_pkg;

  // ==========================================================================
  // register map
  localparam int         ADDR_W           = 12;
  localparam logic [7:0] SCAN_CTRL_IDX    = 8'hb1;
  localparam logic [7:0] BRIGHT_EXTRA_IDX = 8'hb2;
  localparam logic [7:0] SCAN_STATUS_IDX  = 8'hb3;
  localparam logic [ADDR_W-1:0] SCAN_CTRL_ADDR    = {2'h0, SCAN_CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] BRIGHT_EXTRA_ADDR = {2'h0, BRIGHT_EXTRA_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] SCAN_STATUS_ADDR  = {2'h0, SCAN_STATUS_IDX, 2'h0};

  // field positions and reset values
  localparam int         DUTY_LSB      = 6;
  localparam int         DIV_LSB       = 4;
  localparam int         FREEZE_BIT    = 3;
  localparam int         MAIN_BRI_LSB  = 0;
  localparam int         FADE_DIS_BIT  = 7;
  localparam int         SEG5_BRI_LSB  = 4;
  localparam int         SEG4_BRI_LSB  = 0;
  localparam logic [7:0] SCAN_CTRL_RST = 8'h04;
  localparam logic [7:0] EXTRA_RST     = 8'h44;
  localparam logic [7:0] EXTRA_MASK    = 8'hf7;
  localparam logic [2:0] LEVEL_RST     = 3'h4;

  // matrix geometry and timing
  localparam int         NUM_COM  = 4;
  localparam int         MAX_SEG  = 6;
  localparam logic [2:0] SUB_LAST = 3'h7;
  localparam logic [6:0] DIV_BASE = 7'h40;

  typedef enum logic [1:0] {DUTY_OFF, DUTY_8, DUTY_9, DUTY_10} duty_e;

  typedef struct packed {
    logic       fadeDis;
    logic [2:0] seg5Bri;
    logic [2:0] seg4Bri;
    logic [2:0] mainBri;
    logic       freeze;
    logic [1:0] divSel;
    duty_e      duty;
  } scan_cfg_s;

  typedef struct packed {
    logic [MAX_SEG-1:0] segOe;
    logic [MAX_SEG-1:0] segment_drive_line;
    logic [NUM_COM-1:0] comOe;
    logic [NUM_COM-1:0] common_drive_line;
  } led_pins_s;

  // split the two control bytes into fields
  function automatic scan_cfg_s decodeCfg(input logic [7:0] ctl, input logic [7:0] ext);
    scan_cfg_s c;
    c.duty    = duty_e'(ctl[DUTY_LSB +: 2]);
    c.divSel  = ctl[DIV_LSB +: 2];
    c.freeze  = ctl[FREEZE_BIT];
    c.mainBri = ctl[MAIN_BRI_LSB +: 3];
    c.fadeDis = ext[FADE_DIS_BIT];
    c.seg5Bri = ext[SEG5_BRI_LSB +: 3];
    c.seg4Bri = ext[SEG4_BRI_LSB +: 3];
    return c;
  endfunction

  // segment lines used by a duty setting
  function automatic logic [2:0] segCount(input duty_e d);
    return (d == DUTY_OFF) ? 3'h0 : 3'(d) + 3'h3;
  endfunction

  // time slots in one frame: 8, 9 or 10
  function automatic logic [3:0] slotCount(input duty_e d);
    return 4'(d) + 4'h7;
  endfunction

  // divider terminal count: 63, 31, 15 or 7
  function automatic logic [5:0] divLimit(input logic [1:0] sel);
    return 6'((DIV_BASE >> sel) - 7'h1);
  endfunction

endpackage

// >>> test/led_matrix_model.sv
// ============================================================================
// led matrix stand-in: tallies lit and driven cycles seen on the pins
module led_matrix_model
  import led_scan_pkg::*;
(
  // clock and tally clear
  input  wire logic      clk,
  input  wire logic      clear,
  // matrix pins
  input  wire led_pins_s ledPins,
  // tallies
  output logic [15:0]    litCnt [MAX_SEG],
  output logic [15:0]    comCnt [NUM_COM],
  output logic [15:0]    driveCnt,
  output logic [15:0]    clashCnt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [NUM_COM-1:0] comOn;

  // a common only lights leds while it is both driven and high
  assign comOn = ledPins.common_drive_line & ledPins.comOe;

  // count per segment and common, plus any drive and double commons
  always_ff @(posedge clk) begin
    if (clear) begin
      litCnt   <= '{default: 16'h0};
      comCnt   <= '{default: 16'h0};
      driveCnt <= 16'h0;
      clashCnt <= 16'h0;
    end else begin
      for (int s = 0; s < MAX_SEG; s++) begin
        if (ledPins.segOe[s] && ledPins.segment_drive_line[s] && (|comOn)) begin
          litCnt[s] <= litCnt[s] + 16'h1;
        end
      end
      for (int c = 0; c < NUM_COM; c++) begin
        if (comOn[c]) begin
          comCnt[c] <= comCnt[c] + 16'h1;
        end
      end
      if ((|ledPins.segOe) || (|ledPins.comOe)) begin
        driveCnt <= driveCnt + 16'h1;
      end
      if ($countones(comOn) > 1) begin
        clashCnt <= clashCnt + 16'h1;
      end
    end
  end
endmodule // led_matrix_model

// >>> test/testbench.sv
// ============================================================================
// register tests and pin measurements of the scan controller
module testbench
  import led_scan_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic                       clk = 1'b0;
  logic                       sysRst = 1'b1;
  logic                       psel = 1'b0;
  logic                       penable = 1'b0;
  logic                       pwrite = 1'b0;
  logic [ADDR_W-1:0]          paddr = '0;
  logic [31:0]                pwdata = '0;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [NUM_COM*MAX_SEG-1:0] ledPattern = 24'hffffbf;
  led_pins_s                  ledPins;
  logic                       clear = 1'b1;
  logic [15:0]                litCnt [MAX_SEG];
  logic [15:0]                comCnt [NUM_COM];
  logic [15:0]                driveCnt;
  logic [15:0]                clashCnt;
  int                         failures = 0;
  int                         tests_run = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  led_matrix_scan_control u_led_matrix_scan_control (
    .clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ledPattern(ledPattern), .ledPins(ledPins));

  led_matrix_model u_led_matrix_model (
    .clk(clk), .clear(clear), .ledPins(ledPins), .litCnt(litCnt), .comCnt(comCnt),
    .driveCnt(driveCnt), .clashCnt(clashCnt));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("apb answer", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h0, r, e);
    chk("read data", exp, r);
    chk("read error", {31'h0, expErr}, {31'h0, e});
  endtask

  // clear the tallies, then count over n cycles
  task automatic measure(input int n);
    @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("wrong value watchdog expected finish seen hang");
    print_verdict();
  end

  // ==========================================================================
  // main sequence
  initial begin
    static logic [1:0] dutyTab [6] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h1, 2'h1};
    static logic [1:0] divTab  [6] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h1, 2'h2};
    int dv, fr, lvl, on;
    logic [31:0] st0, st1;
    logic        se;
    repeat (4) @(posedge clk);
    sysRst <= 1'b0;
    rd(SCAN_CTRL_ADDR, 32'h04, 1'b0);
    rd(BRIGHT_EXTRA_ADDR, 32'h44, 1'b0);
    rd(12'h000, 32'h0, 1'b1);
    wr(SCAN_STATUS_ADDR, 8'hff);
    measure(256);
    chk("idle drive", 32'h0, {16'h0, driveCnt});
    wr(BRIGHT_EXTRA_ADDR, 8'hff);
    rd(BRIGHT_EXTRA_ADDR, 32'hf7, 1'b0);
    wr(BRIGHT_EXTRA_ADDR, 8'h86);
    $display("test registers done");
    // duty and divider table, main level 2, seg4 level 6, seg5 level 0
    for (int i = 0; i < 6; i++) begin
      wr(SCAN_CTRL_ADDR, {dutyTab[i], divTab[i], 4'h2});
      dv = 64 >> divTab[i];
      fr = (dutyTab[i] + 7) * 8 * dv;
      repeat (fr) @(posedge clk);
      measure(2 * fr);
      for (int c = 0; c < NUM_COM; c++) begin
        chk("common time", 16 * dv, {16'h0, comCnt[c]});
      end
      for (int s = 0; s < MAX_SEG; s++) begin
        lvl = (s < 4) ? 2 : ((s == 4) ? 6 : 0);
        on = (s < dutyTab[i] + 3) ? ((s == 0) ? 3 : 4) : 0;
        chk("segment light", on * (lvl + 1) * dv * 2, {16'h0, litCnt[s]});
      end
      chk("common clash", 32'h0, {16'h0, clashCnt});
    end
    $display("test duty and divider done");
    wr(SCAN_CTRL_ADDR, 8'h7a);
    repeat (3) @(posedge clk);
    measure(512);
    chk("frozen drive", 32'h0, {16'h0, driveCnt});
    // status while frozen: hold flag only, position must not move
    apb(1'b0, SCAN_STATUS_ADDR, 8'h0, st0, se);
    chk("frozen status flags", 32'h2, st0 & 32'hffffff03);
    chk("status error", 32'h0, {31'h0, se});
    repeat (64) @(posedge clk);
    apb(1'b0, SCAN_STATUS_ADDR, 8'h0, st1, se);
    chk("frozen position", st0, st1);
    wr(SCAN_CTRL_ADDR, 8'h72);
    repeat (512) @(posedge clk);
    measure(1024);
    chk("released common time", 32'd128, {16'h0, comCnt[1]});
    wr(SCAN_CTRL_ADDR, 8'h32);
    repeat (3) @(posedge clk);
    measure(512);
    chk("disabled drive", 32'h0, {16'h0, driveCnt});
    $display("test freeze and disable done");
    wr(BRIGHT_EXTRA_ADDR, 8'h06);
    wr(SCAN_CTRL_ADDR, 8'h77);
    repeat (5120) @(posedge clk);
    wr(SCAN_CTRL_ADDR, 8'h70);
    repeat (512) @(posedge clk);
    measure(512);
    chk("smoothed above floor", 32'h1, {31'h0, litCnt[1] > 16'd32});
    repeat (4096) @(posedge clk);
    measure(512);
    chk("smoothed settled", 32'd32, {16'h0, litCnt[1]});
    wr(BRIGHT_EXTRA_ADDR, 8'h86);
    wr(SCAN_CTRL_ADDR, 8'h77);
    repeat (512) @(posedge clk);
    measure(512);
    chk("direct jump", 32'd256, {16'h0, litCnt[1]});
    $display("test smoothing done");
    print_verdict();
  end
endmodule // testbench
